// [verilog/drs_ref_switch_ctrl.sv]
// dpll state control and reference switching for two references
`timescale 1ns/1ps
`default_nettype none
`include "drs_regs.svh"

// Overview of operation
// [R01] unmanaged: own machine picks state and reference
// [R02] managed: controller pins set state and reference
// [R03] entering unmanaged keeps the currently locked reference; code reverts at once to a strictly better usable one
// [R04] switch on failure bits enabled by switch mask
// [R05] holdover on masked failure or no alternative
// [R06] leave auto-holdover once causes disappear
// [R07] failed reference: switch, else holdover
// [R08] pick highest priority available, fall back next
// [R09] three-bit priority, lower wins, 111 excludes
// [R10] equal priority: reference 0 wins, default too
// [R11] no revert on equal priority, revert higher
// [R12] managed: failed selection waits in auto-holdover
// [R13] managed holdover only from holdover-mask failures; code also holds on fail-mask failures and select changes
// [R14] managed holdover entry and exit keep reference
// [R15] select change passes through holdover first
// [R16] control and status bits brought to pins
// [R17] failure indicator: any unmasked monitor high
// [R18] one status bit names reference in use
// [R19] reset loads defaults; all logic on clock
// [R20] freerun until first valid reference acquired
module drs_ref_switch_ctrl
  import drs_pkg::*;
(
  input  wire logic       REF_CLK,              // system clock, 100 MHz
  input  wire logic       RST,                  // async reset, high
  input  wire logic       MANAGED,              // 1 managed, 0 unmanaged (pin)
  input  wire logic [1:0] STATE_CTRL,           // forced dpll state (pin)
  input  wire logic [1:0] REF_SEL_CTRL,         // {enable, reference} (pin)
  input  wire logic       SWITCH_MODE_CTRL,     // 1 hit-less, 0 glitch-less (pin)
  input  wire logic [1:0] LOSS_OF_SIGNAL,       // per reference los pins
  input  wire logic [1:0] SINGLE_CYCLE_MONITOR, // per reference monitor
  input  wire logic [1:0] COARSE_FREQ_MONITOR,  // per reference monitor
  input  wire logic [1:0] GUARD_SOAK_TIMER,     // per reference monitor
  input  wire logic       DPLL_LOCK_IN,         // phase lock from the loop
  input  wire logic       CFG_LOAD,             // pulse: take CFG_IN
  input  wire drs_cfg_t   CFG_IN,               // new configuration
  output logic [1:0]      DPLL_STATE,           // current dpll state
  output logic            REF_USED,             // 0 ref0, 1 ref1
  output logic [1:0]      REF_SEL_STATUS,       // {no ref available, ref used}
  output logic [2:0]      REF_MON_STATUS,       // {ref1 fail, ref0 fail, used fails}
  output logic            HOLDOVER,             // dpll in holdover
  output logic            LOCK,                 // locked in normal state
  output logic            SWITCH_MODE,          // applied switching mode
  output drs_cfg_t        CFG_OUT               // configuration in force
);

  localparam int NREF = 2;
  localparam int CW   = 6;

  // ---------------------------------------------------------------
  // pin synchronisers for the controller-driven bits
  // ---------------------------------------------------------------
  logic [CW-1:0] ctl_meta;
  logic [CW-1:0] ctl_sync;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctl_meta <= '0;
      ctl_sync <= '0;
    end else begin
      ctl_meta <= {MANAGED, STATE_CTRL, REF_SEL_CTRL, SWITCH_MODE_CTRL};
      ctl_sync <= ctl_meta;
    end
  end

  wire        managed = ctl_sync[`DRS_CTL_MANAGED];
  wire  [1:0] st_code = ctl_sync[`DRS_CTL_ST_HI:`DRS_CTL_ST_LO];
  wire        sel_en  = ctl_sync[`DRS_CTL_SEL_EN];
  wire        sel_ref = ctl_sync[`DRS_CTL_SEL_REF];
  wire        sw_mode = ctl_sync[`DRS_CTL_SWMODE];

  drs_state_t st_ctrl;
  assign st_ctrl = drs_state_t'(st_code);

  // ---------------------------------------------------------------
  // configuration store
  // ---------------------------------------------------------------
  drs_cfg_t cfg;

  // masks and priorities come back to their defaults on reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cfg <= DRS_CFG_RST; // [R19]
    end else if (CFG_LOAD) begin
      cfg <= CFG_IN;
    end
  end

  // ---------------------------------------------------------------
  // per-reference qualification
  // ---------------------------------------------------------------
  logic [NREF-1:0] ref_fail;
  logic [NREF-1:0] sw_cond;
  logic [NREF-1:0] ho_cond;
  logic [NREF-1:0] usable;

  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : g_ref
      drs_ref_mon u_mon (
        .clk     (REF_CLK),
        .rst     (RST),
        .los_pin (LOSS_OF_SIGNAL[g]),
        .single_cycle_monitor     (SINGLE_CYCLE_MONITOR[g]),
        .coarse_freq_monitor     (COARSE_FREQ_MONITOR[g]),
        .guard_soak_timer     (GUARD_SOAK_TIMER[g]),
        .cfg     (cfg),
        .prio    (cfg.prio[g]),
        .vec     (),
        .fail    (ref_fail[g]),
        .sw_cond (sw_cond[g]),
        .ho_cond (ho_cond[g]),
        .usable  (usable[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // state held across both modes
  // ---------------------------------------------------------------
  drs_state_t state;
  drs_state_t next_state;
  logic       cur_ref;
  logic       next_ref;
  logic       acquired;
  logic       next_acquired;

  // ---------------------------------------------------------------
  // priority choice
  // ---------------------------------------------------------------
  wire       both_ok   = usable[0] & usable[1];
  wire       any_ok    = usable[0] | usable[1];
  // strict compare keeps reference 0 ahead on a tie
  wire       p1_wins   = cfg.prio[1] < cfg.prio[0];        // [R09] [R10]
  wire       best      = both_ok ? p1_wins : usable[1];    // [R08]
  wire       other     = ~cur_ref;
  wire [2:0] prio_cur  = cfg.prio[cur_ref];
  wire [2:0] prio_best = cfg.prio[best];

  // only a strictly better reference pulls us back
  wire       cur_off   = prio_cur == `DRS_PRIO_OFF;
  wire       upgrade   = any_ok & (best != cur_ref)
                         & ((prio_best < prio_cur) | cur_off);  // [R11]

  // ---------------------------------------------------------------
  // unmanaged decisions
  // ---------------------------------------------------------------
  wire cur_sw    = sw_cond[cur_ref];
  wire cur_ho    = ho_cond[cur_ref];
  wire switch_ok = cur_sw & usable[other];                     // [R07]
  wire no_alt    = cur_sw & ~usable[other];
  wire um_ho     = (cur_ho | no_alt) & ~switch_ok;             // [R05]

  // a switch needs only the alternative to be valid
  wire um_ref    = switch_ok ? other :                         // [R04]
                   upgrade   ? best  : cur_ref;                // [R08]

  drs_state_t um_state;
  assign um_state = um_ho ? DRS_HOLDOVER : DRS_NORMAL;         // [R06]

  // before the first normal state the best reference is only a candidate
  wire        pre_ref   = any_ok ? best : cur_ref;
  drs_state_t pre_state;
  assign pre_state = any_ok ? DRS_NORMAL : DRS_FREERUN;        // [R20]

  // ---------------------------------------------------------------
  // managed decisions
  // ---------------------------------------------------------------
  wire m_ref    = sel_en ? sel_ref : cur_ref;                  // [R02] [R12]
  wire m_change = m_ref != cur_ref;
  // a new selection costs one holdover cycle before lock
  wire m_ho     = ho_cond[cur_ref] | ref_fail[cur_ref]         // [R12] [R13]
                  | m_change;                                  // [R15]

  drs_state_t m_auto;
  drs_state_t m_state;
  assign m_auto = m_ho ? DRS_HOLDOVER : DRS_NORMAL;            // [R14]

  // spare code is read as normal with automatic holdover
  assign m_state = (st_ctrl == DRS_FREERUN)  ? DRS_FREERUN :
                   (st_ctrl == DRS_HOLDOVER) ? DRS_HOLDOVER :
                   m_auto;                                     // [R02]

  // ---------------------------------------------------------------
  // mode multiplexing
  // ---------------------------------------------------------------
  // unmanaged starts from the current reference, then switches or upgrades as usual
  assign next_ref   = managed   ? m_ref :                      // [R03]
                      !acquired ? pre_ref : um_ref;            // [R01]
  assign next_state = managed   ? m_state :
                      !acquired ? pre_state : um_state;        // [R01]
  assign next_acquired = acquired | (next_state == DRS_NORMAL);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state    <= DRS_FREERUN;                                 // [R20]
      cur_ref  <= 1'h0;
      acquired <= 1'h0;
    end else begin
      state    <= next_state;
      cur_ref  <= next_ref;
      acquired <= next_acquired;
    end
  end

  // ---------------------------------------------------------------
  // status outputs, all registered
  // ---------------------------------------------------------------
  wire [2:0] next_mon  = {ref_fail[1], ref_fail[0], ref_fail[cur_ref]};
  wire       next_lock = DPLL_LOCK_IN & (state == DRS_NORMAL);
  wire       next_hold = next_state == DRS_HOLDOVER;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DPLL_STATE     <= `DRS_ST_FREERUN;
      REF_USED       <= 1'h0;
      REF_SEL_STATUS <= 2'h0;
      REF_MON_STATUS <= 3'h0;
      HOLDOVER       <= 1'h0;
      LOCK           <= 1'h0;
      SWITCH_MODE    <= 1'h0;
      CFG_OUT        <= DRS_CFG_RST;
    end else begin
      DPLL_STATE     <= next_state;                            // [R16]
      REF_USED       <= next_ref;                              // [R18]
      REF_SEL_STATUS <= {~any_ok, next_ref};                   // [R16]
      REF_MON_STATUS <= next_mon;                              // [R16]
      HOLDOVER       <= next_hold;                             // [R16]
      LOCK           <= next_lock;                             // [R16]
      SWITCH_MODE    <= sw_mode;                               // [R16]
      CFG_OUT        <= cfg;
    end
  end

endmodule

`default_nettype wire

// [verilog/drs_regs.svh]
// constants for the dpll reference switch control block
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH

// dpll state codes
`define DRS_ST_FREERUN   2'h0
`define DRS_ST_NORMAL    2'h1
`define DRS_ST_HOLDOVER  2'h2
`define DRS_ST_SPARE     2'h3

// failure vector bit positions, shared by all masks
`define DRS_BIT_LOS      0
`define DRS_BIT_SCM      1
`define DRS_BIT_CFM      2
`define DRS_BIT_GST      3

// reset values of the configuration
`define DRS_SWMASK_RST   4'h8
`define DRS_HOLDOVER_MASK_RST   4'h7
`define DRS_FAILMASK_RST 4'hf
`define DRS_PRIO0_RST    3'h0
`define DRS_PRIO1_RST    3'h1

// priority value that removes a reference from selection
`define DRS_PRIO_OFF     3'h7

// positions inside the synchronised control pin vector
`define DRS_CTL_MANAGED  5
`define DRS_CTL_ST_HI    4
`define DRS_CTL_ST_LO    3
`define DRS_CTL_SEL_EN   2
`define DRS_CTL_SEL_REF  1
`define DRS_CTL_SWMODE   0

`endif

// [verilog/drs_pkg.sv]
// types for the dpll reference switch control block
`include "drs_regs.svh"

package drs_pkg;

  typedef enum logic [1:0] {
    DRS_FREERUN  = `DRS_ST_FREERUN,
    DRS_NORMAL   = `DRS_ST_NORMAL,
    DRS_HOLDOVER = `DRS_ST_HOLDOVER,
    DRS_SPARE    = `DRS_ST_SPARE
  } drs_state_t;

  typedef struct packed {
    logic [3:0]      ref_switch_mask;
    logic [3:0]      holdover_mask;
    logic [3:0]      fail_mask;
    logic [1:0][2:0] prio;
  } drs_cfg_t;

  typedef struct packed {
    logic guard_soak_timer;
    logic coarse_freq_monitor;
    logic single_cycle_monitor;
    logic loss_of_signal;
  } drs_mon_t;

  localparam drs_cfg_t DRS_CFG_RST = '{
    ref_switch_mask: `DRS_SWMASK_RST,
    holdover_mask:   `DRS_HOLDOVER_MASK_RST,
    fail_mask:       `DRS_FAILMASK_RST,
    prio:            {`DRS_PRIO1_RST, `DRS_PRIO0_RST}
  };

endpackage

// [verilog/drs_ref_mon.sv]
// per-reference failure qualification
`timescale 1ns/1ps
`default_nettype none
`include "drs_regs.svh"

module drs_ref_mon
  import drs_pkg::*;
(
  input  wire logic       clk,        // system clock
  input  wire logic       rst,        // async reset, high
  input  wire logic       los_pin,    // loss_of_signal pin, async
  input  wire logic       single_cycle_monitor,        // single_cycle_monitor indicator
  input  wire logic       coarse_freq_monitor,        // coarse_freq_monitor indicator
  input  wire logic       guard_soak_timer,        // guard_soak_timer indicator
  input  wire drs_cfg_t   cfg,        // live configuration
  input  wire logic [2:0] prio,       // this reference's priority
  output logic [3:0]      vec,        // registered raw indicators
  output logic            fail,       // overall failure indicator
  output logic            sw_cond,    // switch condition
  output logic            ho_cond,    // holdover condition
  output logic            usable      // may be selected
);

  logic     los_meta;
  logic     los_sync;
  drs_mon_t mon;

  // los is a pin; monitors are same-clock logic
  // indicators read as failed until first sampled, so reset values pick no reference
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      los_meta <= 1'h1;
      los_sync <= 1'h1;
      mon      <= '1;
    end else begin
      los_meta <= los_pin;
      los_sync <= los_meta;
      mon      <= '{guard_soak_timer: guard_soak_timer, coarse_freq_monitor: coarse_freq_monitor, single_cycle_monitor: single_cycle_monitor, loss_of_signal: los_sync};
    end
  end

  assign vec[`DRS_BIT_LOS] = mon.loss_of_signal;
  assign vec[`DRS_BIT_SCM] = mon.single_cycle_monitor;
  assign vec[`DRS_BIT_CFM] = mon.coarse_freq_monitor;
  assign vec[`DRS_BIT_GST] = mon.guard_soak_timer;

  assign fail    = |(vec & cfg.fail_mask);        // [R17]
  assign sw_cond = |(vec & cfg.ref_switch_mask);  // [R04]
  assign ho_cond = |(vec & cfg.holdover_mask);    // [R05]
  assign usable  = ~fail & (prio != `DRS_PRIO_OFF); // [R09]

endmodule

`default_nettype wire

// [testbench/drs_ref_switch_ctrl_sva.sv]
// port-level assertions for the reference switch control block
`timescale 1ns/1ps
`default_nettype none
module drs_ref_switch_ctrl_sva
  import drs_pkg::*;
(
  input wire logic       REF_CLK,              // clock
  input wire logic       RST,                  // reset
  input wire logic       MANAGED,              // mode pin
  input wire logic       SWITCH_MODE_CTRL,     // mode pin
  input wire logic [1:0] LOSS_OF_SIGNAL,       // monitor
  input wire logic [1:0] SINGLE_CYCLE_MONITOR, // monitor
  input wire logic [1:0] COARSE_FREQ_MONITOR,  // monitor
  input wire logic [1:0] GUARD_SOAK_TIMER,     // monitor
  input wire logic       CFG_LOAD,             // strobe
  input wire drs_cfg_t   CFG_IN,               // new config
  input wire logic [1:0] DPLL_STATE,           // state
  input wire logic       REF_USED,             // used ref
  input wire logic [1:0] REF_SEL_STATUS,       // status
  input wire logic [2:0] REF_MON_STATUS,       // status
  input wire logic       HOLDOVER,             // flag
  input wire logic       SWITCH_MODE,          // applied mode
  input wire drs_cfg_t   CFG_OUT               // config
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire logic mon_any = |{LOSS_OF_SIGNAL, SINGLE_CYCLE_MONITOR, COARSE_FREQ_MONITOR,
                         GUARD_SOAK_TIMER};
  // long windows absorb the pin synchronisers
  sequence s_managed_steady;
    MANAGED [*6];
  endsequence
  sequence s_unmanaged_quiet;
    (!MANAGED && !mon_any) [*8];
  endsequence
  a_holdover_flag: assert property (HOLDOVER == (DPLL_STATE == DRS_HOLDOVER))
    else $error("holdover flag disagrees with state");
  a_used_status: assert property (REF_SEL_STATUS[0] == REF_USED)
    else $error("select status disagrees with used reference");
  a_reset_state: assert property ($fell(RST) |-> DPLL_STATE == DRS_FREERUN
    && !REF_USED && CFG_OUT == DRS_CFG_RST) else $error("wrong state after reset");
  a_cfg_load: assert property (CFG_LOAD |-> ##2 CFG_OUT == $past(CFG_IN, 2))
    else $error("loaded configuration not shown");
  a_swmode_follow: assert property ($stable(SWITCH_MODE_CTRL) [*5] |->
    SWITCH_MODE == SWITCH_MODE_CTRL) else $error("switch mode not applied");
  a_mon_fail: assert property ((SINGLE_CYCLE_MONITOR[0] && CFG_OUT.fail_mask[1]) [*4] |->
    REF_MON_STATUS[1]) else $error("reference 0 failure not flagged");
  a_excluded_ref: assert property ((!MANAGED && CFG_OUT.prio[1] == 3'h7) [*8] |->
    !(REF_USED && DPLL_STATE == DRS_NORMAL)) else $error("excluded reference in use");
  a_select_holdover: assert property (s_managed_steady ##0 ($changed(REF_USED) &&
    $past(DPLL_STATE) == DRS_NORMAL) |-> HOLDOVER) else $error("select change skipped holdover");
  a_holdover_exit: assert property (s_unmanaged_quiet ##0 !REF_SEL_STATUS[1]
    |-> !HOLDOVER) else $error("holdover kept without cause");
endmodule
`default_nettype wire

// [testbench/drs_ctrl_model.sv]
// external controller model driving the managed-mode pins
`timescale 1ns/1ps
`default_nettype none
module drs_ctrl_model (
  input  wire logic       clk,        // system clock
  output logic            managed,    // mode pin
  output logic [1:0]      state_ctrl, // forced state
  output logic [1:0]      ref_sel,    // {enable, reference}
  output logic            sw_mode     // switching mode pin
);
  // unmanaged at start, yet asking for holdover so that ignoring it is visible
  initial begin
    managed = 1'b0;
    state_ctrl = 2'h2;
    ref_sel = 2'h3;
    sw_mode = 1'b0;
  end
  task automatic drive(input logic m, input logic [1:0] st, input logic [1:0] sel,
                       input logic sm);
    @(posedge clk);
    managed <= m;
    state_ctrl <= st;
    ref_sel <= sel;
    sw_mode <= sm;
  endtask
endmodule
`default_nettype wire

// [testbench/drs_ref_switch_ctrl_tb.sv]
// self-checking bench for the reference switch control block
`timescale 1ns/1ps
`default_nettype none
module drs_ref_switch_ctrl_tb;
  import drs_pkg::*;
  typedef struct packed {
    drs_mon_t   m0;
    drs_mon_t   m1;
    drs_state_t st;
    logic       used;
  } drs_row_t;
  logic REF_CLK, RST, MANAGED, SWITCH_MODE_CTRL, REF_USED, HOLDOVER, LOCK, SWITCH_MODE, CFG_LOAD;
  logic [1:0] STATE_CTRL, REF_SEL_CTRL, LOSS_OF_SIGNAL, SINGLE_CYCLE_MONITOR;
  logic [1:0] COARSE_FREQ_MONITOR, GUARD_SOAK_TIMER, DPLL_STATE, REF_SEL_STATUS;
  logic [2:0] REF_MON_STATUS;
  drs_cfg_t   CFG_IN, CFG_OUT;
  logic       DPLL_LOCK_IN;
  // what the bench last applied, for the expected status bits
  drs_mon_t   mon0, mon1;
  drs_cfg_t   cfg_now;
  int         error_cnt = 0;
  int         tests_run = 0;
  // rows run in order, each starting from the state the previous one left
  drs_row_t rows [8] = '{'{4'h0, 4'h0, DRS_NORMAL, 1'b0}, '{4'h8, 4'h0, DRS_NORMAL, 1'b1},
    '{4'h0, 4'h0, DRS_NORMAL, 1'b0}, '{4'h2, 4'h0, DRS_HOLDOVER, 1'b0},
    '{4'h0, 4'h0, DRS_NORMAL, 1'b0}, '{4'h8, 4'h8, DRS_HOLDOVER, 1'b0},
    '{4'h1, 4'h0, DRS_HOLDOVER, 1'b0}, '{4'h0, 4'h4, DRS_NORMAL, 1'b0}};
  drs_ref_switch_ctrl drs_ref_switch_ctrl_inst (.REF_CLK(REF_CLK), .RST(RST), .MANAGED(MANAGED),
    .STATE_CTRL(STATE_CTRL), .REF_SEL_CTRL(REF_SEL_CTRL), .SWITCH_MODE_CTRL(SWITCH_MODE_CTRL),
    .LOSS_OF_SIGNAL(LOSS_OF_SIGNAL), .SINGLE_CYCLE_MONITOR(SINGLE_CYCLE_MONITOR),
    .COARSE_FREQ_MONITOR(COARSE_FREQ_MONITOR), .GUARD_SOAK_TIMER(GUARD_SOAK_TIMER),
    .DPLL_LOCK_IN(DPLL_LOCK_IN), .CFG_LOAD(CFG_LOAD), .CFG_IN(CFG_IN), .DPLL_STATE(DPLL_STATE),
    .REF_USED(REF_USED), .REF_SEL_STATUS(REF_SEL_STATUS), .REF_MON_STATUS(REF_MON_STATUS),
    .HOLDOVER(HOLDOVER), .LOCK(LOCK), .SWITCH_MODE(SWITCH_MODE), .CFG_OUT(CFG_OUT));
  drs_ctrl_model drs_ctrl_model_inst (.clk(REF_CLK), .managed(MANAGED), .state_ctrl(STATE_CTRL),
    .ref_sel(REF_SEL_CTRL), .sw_mode(SWITCH_MODE_CTRL));
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic bad(input string msg);
    error_cnt++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic set_mon(input drs_mon_t a, input drs_mon_t b);
    @(posedge REF_CLK);
    LOSS_OF_SIGNAL <= {b.loss_of_signal, a.loss_of_signal};
    SINGLE_CYCLE_MONITOR <= {b.single_cycle_monitor, a.single_cycle_monitor};
    COARSE_FREQ_MONITOR <= {b.coarse_freq_monitor, a.coarse_freq_monitor};
    GUARD_SOAK_TIMER <= {b.guard_soak_timer, a.guard_soak_timer};
    mon0 = a;
    mon1 = b;
  endtask
  // eight cycles cover the slowest path, a los pin through its synchroniser
  task automatic check(input drs_state_t st, input logic used);
    logic       f0, f1, noref;
    logic [2:0] want_mon;
    repeat (8) @(posedge REF_CLK);
    #1;
    f0       = |(mon0 & cfg_now.fail_mask);
    f1       = |(mon1 & cfg_now.fail_mask);
    noref    = (f0 | (cfg_now.prio[0] == 3'h7)) & (f1 | (cfg_now.prio[1] == 3'h7));
    want_mon = {f1, f0, used ? f1 : f0};
    tests_run++;
    if (DPLL_STATE !== st || REF_USED !== used ||
        HOLDOVER !== (st == DRS_HOLDOVER) || LOCK !== (st == DRS_NORMAL && DPLL_LOCK_IN)) begin
      bad($sformatf("state %0d used %0b, want %0d %0b", DPLL_STATE, REF_USED, st, used));
    end
    tests_run++;
    if (REF_SEL_STATUS !== {noref, used} || REF_MON_STATUS !== want_mon) begin
      bad($sformatf("status %0h mon %0h, want %0h %0h", REF_SEL_STATUS, REF_MON_STATUS,
                    {noref, used}, want_mon));
    end
  endtask
  task automatic check_reset();
    tests_run++;
    if (DPLL_STATE !== DRS_FREERUN || REF_USED !== 1'b0 ||
        CFG_OUT !== DRS_CFG_RST || REF_SEL_STATUS !== 2'h0 ||
        REF_MON_STATUS !== 3'h0 || HOLDOVER !== 1'b0 || LOCK !== 1'b0) begin
      bad("wrong values in reset");
    end
  endtask
  task automatic load(input logic [2:0] p0, input logic [2:0] p1);
    drs_cfg_t c;
    c = DRS_CFG_RST;
    c.prio = {p1, p0};
    @(posedge REF_CLK);
    CFG_IN <= c;
    CFG_LOAD <= 1'b1;
    cfg_now = c;
    @(posedge REF_CLK);
    CFG_LOAD <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1;
    tests_run++;
    if (CFG_OUT !== c) begin
      bad("configuration not taken");
    end
  endtask
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  initial begin
    repeat (20000) @(posedge REF_CLK);
    bad("watchdog expired");
    summarize();
  end
  initial begin
    RST = 1'b1;
    CFG_LOAD = 1'b0;
    CFG_IN = DRS_CFG_RST;
    DPLL_LOCK_IN = 1'b1;
    mon0 = '0;
    mon1 = '0;
    cfg_now = DRS_CFG_RST;
    {LOSS_OF_SIGNAL, SINGLE_CYCLE_MONITOR, COARSE_FREQ_MONITOR, GUARD_SOAK_TIMER} = 8'h00;
    repeat (4) @(posedge REF_CLK);
    #1;
    check_reset();
    repeat (4) @(posedge REF_CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      set_mon(rows[i].m0, rows[i].m1);
      check(rows[i].st, rows[i].used);
    end
    set_mon(4'h0, 4'h0);
    check(DRS_NORMAL, 1'b0);
    load(3'h2, 3'h2);
    set_mon(4'h8, 4'h0);
    check(DRS_NORMAL, 1'b1);
    set_mon(4'h0, 4'h0);
    check(DRS_NORMAL, 1'b1);
    drs_ctrl_model_inst.drive(1'b1, 2'h1, 2'h3, 1'b1);
    check(DRS_NORMAL, 1'b1);
    drs_ctrl_model_inst.drive(1'b1, 2'h1, 2'h2, 1'b1);
    check(DRS_NORMAL, 1'b0);
    set_mon(4'h2, 4'h0);
    check(DRS_HOLDOVER, 1'b0);
    set_mon(4'h0, 4'h8);
    check(DRS_NORMAL, 1'b0);
    drs_ctrl_model_inst.drive(1'b1, 2'h1, 2'h3, 1'b1);
    check(DRS_HOLDOVER, 1'b1);
    set_mon(4'h0, 4'h0);
    check(DRS_NORMAL, 1'b1);
    drs_ctrl_model_inst.drive(1'b1, 2'h2, 2'h3, 1'b1);
    check(DRS_HOLDOVER, 1'b1);
    drs_ctrl_model_inst.drive(1'b1, 2'h0, 2'h3, 1'b0);
    check(DRS_FREERUN, 1'b1);
    drs_ctrl_model_inst.drive(1'b1, 2'h1, 2'h3, 1'b0);
    check(DRS_NORMAL, 1'b1);
    drs_ctrl_model_inst.drive(1'b0, 2'h2, 2'h2, 1'b0);
    check(DRS_NORMAL, 1'b1);
    load(3'h0, 3'h7);
    check(DRS_NORMAL, 1'b0);
    // lock status follows the loop only while the state is normal
    @(posedge REF_CLK);
    DPLL_LOCK_IN <= 1'b0;
    check(DRS_NORMAL, 1'b0);
    @(posedge REF_CLK);
    DPLL_LOCK_IN <= 1'b1;
    set_mon(4'h8, 4'h0);
    check(DRS_HOLDOVER, 1'b0);
    // a reset in mid-run must restore default masks and priorities
    @(posedge REF_CLK);
    RST <= 1'b1;
    cfg_now = DRS_CFG_RST;
    repeat (2) @(posedge REF_CLK);
    #1;
    check_reset();
    @(posedge REF_CLK);
    RST <= 1'b0;
    check(DRS_NORMAL, 1'b1);
    summarize();
  end
endmodule
bind drs_ref_switch_ctrl drs_ref_switch_ctrl_sva drs_ref_switch_ctrl_sva_inst (.REF_CLK(REF_CLK),
  .RST(RST), .MANAGED(MANAGED), .SWITCH_MODE_CTRL(SWITCH_MODE_CTRL),
  .LOSS_OF_SIGNAL(LOSS_OF_SIGNAL), .SINGLE_CYCLE_MONITOR(SINGLE_CYCLE_MONITOR),
  .COARSE_FREQ_MONITOR(COARSE_FREQ_MONITOR), .GUARD_SOAK_TIMER(GUARD_SOAK_TIMER),
  .CFG_LOAD(CFG_LOAD), .CFG_IN(CFG_IN), .DPLL_STATE(DPLL_STATE), .REF_USED(REF_USED),
  .REF_SEL_STATUS(REF_SEL_STATUS), .REF_MON_STATUS(REF_MON_STATUS), .HOLDOVER(HOLDOVER),
  .SWITCH_MODE(SWITCH_MODE), .CFG_OUT(CFG_OUT));
`default_nettype wire
